// ===== iag_top.sv
// indexed effective-address generator with auto-modify and pointer fetch
module iag_top (
  input wire logic clock,                    // core clock
  input wire logic rst,                      // sync reset, high
  input wire logic req_valid,                // operand request
  input wire iag_pkg::iag_req_t req,         // decoded operand request
  input wire iag_pkg::iag_regs_t regs,       // current register values
  output logic req_ready,                    // block idle
  output logic mem_rd_req,                   // pointer word read
  output logic [15:0] mem_addr,              // pointer address
  input wire logic [15:0] mem_rdata,         // pointer word
  input wire logic mem_rvalid,               // pointer word valid
  output logic done,                         // result valid pulse
  output iag_pkg::iag_res_t res              // result
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iag_pkg::iag_state_s_t st_ff;
  iag_pkg::iag_state_s_t nxt_st;

  logic accept;
  logic [7:0] pb;
  logic is_ext;
  logic is_auto;
  logic is_off5;
  logic is_acc;
  logic is_ind;
  logic is_move;
  logic bad;
  logic [1:0] rr;
  logic [15:0] pc_ref;
  logic [15:0] c_base;
  logic [15:0] c_adj;
  logic [15:0] c_mod;
  logic [15:0] c_off;
  logic [15:0] c_ea;
  iag_pkg::iag_amode_t dst_m;

  function automatic logic [15:0] pick_base(input logic [1:0] sel, input iag_pkg::iag_regs_t r,
                                            input logic [15:0] pcv);
    case (sel)
      iag_pkg::RR_FIRST: pick_base = r.x;
      iag_pkg::RR_SECOND: pick_base = r.y;
      iag_pkg::RR_STACK: pick_base = r.sp;
      default: pick_base = pcv;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // postbyte decode and address math
  // ----------------------------------------------------------------
  assign accept = req_valid && req_ready;
  assign pb = req.postbyte;
  assign is_move = req.kind == iag_pkg::IAG_OP_MOVE;
  assign is_ext = pb[7:5] == iag_pkg::EXT_FORM;
  assign is_off5 = !is_ext && !pb[5];
  assign is_auto = !is_ext && pb[5];
  assign is_acc = is_ext && pb[2];
  assign is_ind = is_acc && pb[1:0] == iag_pkg::ACC_WIDE_IND;
  assign rr = is_ext ? pb[4:3] : pb[7:6];

  // moves see the raw queue pointer; others a queue-free reference
  assign pc_ref = is_move ? regs.pc_raw : req.instr_start + {12'h000, req.instr_len};
  assign c_base = pick_base(rr, regs, pc_ref);
  assign c_adj = pb[3] ? {12'hFFF, pb[3:0]} : {13'h0000, pb[2:0]} + iag_pkg::ADJ_ONE;
  assign c_mod = c_base + c_adj;

  always_comb begin
    c_off = 16'h0000;
    if (is_off5) begin
      c_off = {{11{pb[4]}}, pb[4:0]};
    end else if (is_acc) begin
      case (pb[1:0])
        iag_pkg::ACC_FIRST: c_off = {8'h00, regs.a};
        iag_pkg::ACC_SECOND: c_off = {8'h00, regs.b};
        default: c_off = {regs.a, regs.b};
      endcase
    end
  end

  // pre form uses the adjusted value, post form the original
  assign c_ea = is_auto ? (pb[4] ? c_base : c_mod) : c_base + c_off;

  assign dst_m = (req.prefix == iag_pkg::PAGE2_PREFIX &&
                  req.opcode == iag_pkg::BYTE_MOVE_EXT_IDX_OP) ? iag_pkg::IAG_AM_IDX
                 : req.dst_mode;

  always_comb begin
    bad = 1'b0;
    if (is_auto && rr == iag_pkg::RR_PC) begin
      bad = 1'b1;
    end
    if (is_ext && !pb[2]) begin
      bad = 1'b1; // long constant forms are not handled here
    end
    if (is_move && dst_m == iag_pkg::IAG_AM_IMM) begin
      bad = 1'b1;
    end
    // operand modes must be immediate, extended or indexed
    if (is_move && (dst_m == iag_pkg::IAG_AM_NONE ||
                    req.src_mode == iag_pkg::IAG_AM_NONE)) begin
      bad = 1'b1;
    end
    if (is_move && is_ind) begin
      bad = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.st)
      iag_pkg::IAG_ST_IDLE: begin
        if (accept) begin
          nxt_st.res = '0;
          nxt_st.res.illegal = bad;
          nxt_st.res.ea = c_ea;
          if (!bad) begin
            if (is_auto) begin
              nxt_st.res.wb_en = 1'b1;
              nxt_st.res.wb_reg = rr;
              nxt_st.res.wb_val = c_mod;
            end
            if (req.kind == iag_pkg::IAG_OP_LEA) begin
              nxt_st.res.lea_en = 1'b1;
              nxt_st.res.lea_reg = req.lea_reg;
              nxt_st.res.lea_val = c_ea;
              if (is_auto && req.lea_reg == rr) begin
                nxt_st.res.wb_en = 1'b0;
              end
            end
          end
          // only jumps load the program counter, direct or through a pointer
          nxt_st.res.pc_load = !bad && req.kind == iag_pkg::IAG_OP_JMP;
          if (is_ind && !bad) begin
            nxt_st.ptr_addr = c_ea;
            nxt_st.st = iag_pkg::IAG_ST_PTR;
          end else begin
            nxt_st.done = 1'b1;
            nxt_st.st = iag_pkg::IAG_ST_DONE;
          end
        end
      end
      iag_pkg::IAG_ST_PTR: begin
        if (mem_rvalid) begin
          nxt_st.res.ea = mem_rdata;
          nxt_st.res.lea_val = mem_rdata;
          nxt_st.done = 1'b1;
          nxt_st.st = iag_pkg::IAG_ST_DONE;
        end
      end
      iag_pkg::IAG_ST_DONE: begin
        nxt_st.st = iag_pkg::IAG_ST_IDLE;
      end
      default: begin
        nxt_st.st = iag_pkg::IAG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '{st: iag_pkg::IAG_ST_IDLE, done: 1'b0, ptr_addr: iag_pkg::ADDR_RST, res: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign req_ready = st_ff.st == iag_pkg::IAG_ST_IDLE;
  assign mem_rd_req = st_ff.st == iag_pkg::IAG_ST_PTR;
  assign mem_addr = st_ff.ptr_addr;
  assign done = st_ff.done;
  assign res = st_ff.res;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_auto_pc_base: assert property (accept && is_auto && rr == iag_pkg::RR_PC |=> done && res.illegal && !res.wb_en) else $error("auto-modify on pc accepted");
  a_pre_modify: assert property (accept && is_auto && !pb[4] && !bad |=> done && res.ea == $past(c_mod) && res.wb_val == $past(c_mod)) else $error("pre form address wrong");
  a_post_modify: assert property (accept && is_auto && pb[4] && !bad |=> done && res.ea == $past(c_base) && res.wb_val == $past(c_mod)) else $error("post form address wrong");
  a_adj_range: assert property (is_auto |-> c_adj != 16'h0000 && (c_adj <= 16'h0008 || c_adj >= 16'hFFF8)) else $error("adjust out of range");
  a_lea_same_reg: assert property (accept && is_auto && !bad && req.kind == iag_pkg::IAG_OP_LEA && req.lea_reg == rr |=> res.lea_val == res.ea && !res.wb_en) else $error("lea result differs from address");
  a_acc_offset: assert property (accept && is_acc && pb[1:0] == iag_pkg::ACC_SECOND && !bad |=> res.ea == $past(c_base + {8'h00, regs.b})) else $error("accumulator offset wrong");
  a_acc_no_wb: assert property (accept && is_acc |=> !res.wb_en) else $error("accumulator offset wrote a register");
  a_ind_fetch: assert property (accept && is_ind && !bad |=> mem_rd_req && mem_addr == $past(c_base + {regs.a, regs.b})) else $error("pointer fetch address wrong");
  a_ind_result: assert property (mem_rd_req && mem_rvalid |=> done && res.ea == $past(mem_rdata)) else $error("pointer not used as address");
  a_move_imm_dst: assert property (accept && is_move && dst_m == iag_pkg::IAG_AM_IMM |=> res.illegal) else $error("immediate move destination accepted");
  a_move_ind: assert property (accept && is_move && is_ind |=> done && res.illegal) else $error("indirect move operand accepted");
  a_pc_ref: assert property (accept && !is_move && is_off5 && rr == iag_pkg::RR_PC |=> res.ea == $past(req.instr_start + {12'h000, req.instr_len} + c_off)) else $error("pc reference wrong");
  a_move_c2: assert property (accept && is_move && req.prefix == iag_pkg::PAGE2_PREFIX && req.opcode == iag_pkg::BYTE_MOVE_EXT_IDX_OP && pb == 8'hC2 |=> !res.illegal && res.ea == $past(regs.pc_raw + 16'h0002)) else $error("byte ext-to-idx move decode wrong");

  c_post_inc: cover property (accept && is_auto && pb[4] && !bad ##1 done);
  c_ind_jump: cover property (accept && is_ind && req.kind == iag_pkg::IAG_OP_JMP ##[1:8] done && res.pc_load);
  c_move_ok: cover property (accept && is_move && !bad ##1 done);
  c_lea_same: cover property (accept && is_auto && req.kind == iag_pkg::IAG_OP_LEA && req.lea_reg == rr);

endmodule

// ===== iag_pkg.sv
// constants and types for the indexed address generator
// What this block does
// - auto-modify base excludes the program counter
// - pre forms address with adjusted register value
// - post forms address first, then adjust register
// - adjustment is -8..-1 or +1..+8
// - load-ea on modified register returns operand address
// - accumulator offset: base plus unsigned accumulator
// - accumulator offset changes no register
// - wide accumulator indirect fetches pointer as address
// - moves: immediate destination is illegal
// - moves: no indirect or long-offset postbytes
// - move base may be any of four
// - non-moves: pc reference is byte after instruction
// - non-moves: pc reference independent of queue
// - prefix 18, opcode 09 is byte ext-to-idx move
// - rr field: first, second, stack, pc
// - auto postbyte: p bit and nnnn encoding
// - accumulator postbyte aa select and indirect
package iag_pkg;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE2_PREFIX = 8'h18;
  localparam logic [7:0] BYTE_MOVE_EXT_IDX_OP = 8'h09;
  localparam logic [1:0] RR_FIRST = 2'h0;
  localparam logic [1:0] RR_SECOND = 2'h1;
  localparam logic [1:0] RR_STACK = 2'h2;
  localparam logic [1:0] RR_PC = 2'h3;
  localparam logic [1:0] ACC_FIRST = 2'h0;
  localparam logic [1:0] ACC_SECOND = 2'h1;
  localparam logic [1:0] ACC_WIDE = 2'h2;
  localparam logic [1:0] ACC_WIDE_IND = 2'h3;
  localparam logic [2:0] EXT_FORM = 3'h7;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] ADJ_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IAG_OP_PLAIN = 2'b00,
    IAG_OP_LEA = 2'b01,
    IAG_OP_JMP = 2'b10,
    IAG_OP_MOVE = 2'b11
  } iag_kind_t;

  typedef enum logic [1:0] {
    IAG_AM_IMM = 2'b00,
    IAG_AM_EXT = 2'b01,
    IAG_AM_IDX = 2'b10,
    IAG_AM_NONE = 2'b11
  } iag_amode_t;

  typedef enum logic [1:0] {
    IAG_ST_IDLE = 2'b00,
    IAG_ST_PTR = 2'b01,
    IAG_ST_DONE = 2'b10
  } iag_state_t;

  typedef struct packed {
    iag_kind_t kind;
    logic [1:0] lea_reg;
    logic [7:0] prefix;
    logic [7:0] opcode;
    iag_amode_t src_mode;
    iag_amode_t dst_mode;
    logic [7:0] postbyte;
    logic [15:0] instr_start;
    logic [3:0] instr_len;
  } iag_req_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] pc_raw;
    logic [7:0] a;
    logic [7:0] b;
  } iag_regs_t;

  typedef struct packed {
    logic [15:0] ea;
    logic wb_en;
    logic [1:0] wb_reg;
    logic [15:0] wb_val;
    logic lea_en;
    logic [1:0] lea_reg;
    logic [15:0] lea_val;
    logic pc_load;
    logic illegal;
  } iag_res_t;

  typedef struct packed {
    iag_state_t st;
    logic done;
    logic [15:0] ptr_addr;
    iag_res_t res;
  } iag_state_s_t;

endpackage

// ===== iag_mem_model.sv
// pointer memory on the far side of the address generator
module iag_mem_model (
  input wire logic clock,             // core clock
  input wire logic rst,               // sync reset, high
  input wire logic mem_rd_req,        // pointer read level
  input wire logic [15:0] mem_addr,   // pointer address
  input wire logic [1:0] lat,         // answer delay in cycles
  output logic [15:0] mem_rdata,      // pointer word
  output logic mem_rvalid             // pointer word valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_ff;
  logic [15:0] word;
  always_ff @(posedge clock) begin
    wait_ff <= (rst || !mem_rd_req) ? 2'h0 : wait_ff + {1'b0, wait_ff != 2'h3};
  end
  assign word = {mem_addr[7:0], mem_addr[15:8]} ^ 16'h5A5A;
  assign mem_rvalid = mem_rd_req && (wait_ff >= lat);
  // no stale word outside the answer
  assign mem_rdata = mem_rvalid ? word : ~word;
endmodule

// ===== indexed_address_generator_bench.sv
// self-checking bench for the indexed address generator
module indexed_address_generator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, mem_rd_req, mem_rvalid, done;
  logic [15:0] mem_addr, mem_rdata;
  logic [1:0] lat = 2'h0;
  logic [31:0] lfsr = 32'h7;
  iag_pkg::iag_req_t rq = '0;
  iag_pkg::iag_regs_t rg = '0;
  iag_pkg::iag_res_t res, pend[$];
  int mismatches = 0, comparisons = 0;

  iag_top uut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(rq), .regs(rg),
    .req_ready(req_ready), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .done(done), .res(res));
  iag_mem_model mem (.clock(clock), .rst(rst), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
    .lat(lat), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    for (int k = 0; k < 32; k++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end
    return lfsr;
  endfunction

  function automatic iag_pkg::iag_res_t model(iag_pkg::iag_req_t q, iag_pkg::iag_regs_t g);
    iag_pkg::iag_res_t e;
    logic [7:0] p;
    logic [15:0] bv [4];
    logic [15:0] nv;
    logic [15:0] pt;
    logic [1:0] r;
    logic mv;
    e = '0;
    p = q.postbyte;
    mv = q.kind == iag_pkg::IAG_OP_MOVE;
    bv[0] = g.x;
    bv[1] = g.y;
    bv[2] = g.sp;
    bv[3] = mv ? g.pc_raw : q.instr_start + {12'h000, q.instr_len};
    r = (p[7:5] == 3'h7) ? p[4:3] : p[7:6];
    e.illegal = (p[7:5] == 3'h7 && !p[2]) || (mv && p[7:5] == 3'h7 && p[2:0] == 3'h7)
      || (mv && (q.dst_mode == iag_pkg::IAG_AM_IMM || q.dst_mode == iag_pkg::IAG_AM_NONE)
        && !(q.prefix == 8'h18 && q.opcode == 8'h09))
      || (mv && q.src_mode == iag_pkg::IAG_AM_NONE);
    if (p[7:5] != 3'h7 && !p[5]) begin
      e.ea = bv[r] + {{11{p[4]}}, p[4:0]};
    end else if (p[7:5] != 3'h7) begin
      nv = bv[r] + (p[3] ? {12'hFFF, p[3:0]} : {12'h000, p[3:0]} + 16'h0001);
      e.ea = p[4] ? bv[r] : nv;
      e.wb_en = 1'b1;
      e.wb_reg = r;
      e.wb_val = nv;
    end else if (p[1:0] != 2'h3) begin
      e.ea = bv[r] + (p[1] ? {g.a, g.b} : {8'h00, p[0] ? g.b : g.a});
    end else begin
      pt = bv[r] + {g.a, g.b};
      e.ea = {pt[7:0], pt[15:8]} ^ 16'h5A5A;
    end
    if (q.kind == iag_pkg::IAG_OP_LEA && !e.illegal) begin
      e.lea_en = 1'b1;
      e.lea_reg = q.lea_reg;
      e.lea_val = e.ea;
      if (e.wb_en && e.wb_reg == q.lea_reg) e.wb_en = 1'b0;
    end
    e.pc_load = q.kind == iag_pkg::IAG_OP_JMP && !e.illegal;
    return e;
  endfunction

  function automatic iag_pkg::iag_res_t msk(iag_pkg::iag_res_t v);
    if (v.illegal) begin
      v = '0;
      v.illegal = 1'b1;
    end
    if (!v.wb_en) {v.wb_reg, v.wb_val} = '0;
    if (!v.lea_en) {v.lea_reg, v.lea_val} = '0;
    return v;
  endfunction

  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic issue(iag_pkg::iag_req_t q, iag_pkg::iag_regs_t g);
    logic [31:0] w;
    w = rnd();
    @(posedge clock);
    rq <= q;
    rg <= g;
    req_valid <= 1'b1;
    lat <= w[1:0];
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    pend.push_back(model(q, g));
    req_valid <= 1'b0;
  endtask

  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, reset, result watcher, watchdog
  // ----------------------------------------------------------------
  initial forever #5 clock = ~clock;
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
  end
  always @(negedge clock) begin
    if (done === 1'b1 && pend.size() == 0) begin
      chk("done", {63'h0, done}, 64'h0);
    end else if (done === 1'b1) begin
      chk("res", {8'h00, msk(res)}, {8'h00, msk(pend.pop_front())});
    end
  end
  initial begin
    #100000;
    mismatches++;
    conclude();
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    iag_pkg::iag_req_t q;
    iag_pkg::iag_regs_t g;
    logic [63:0] w;
    logic [95:0] v;
    repeat (9) @(posedge clock);
    for (int i = 0; i < 400; i++) begin
      w = {rnd(), rnd()};
      v = {rnd(), rnd(), rnd()};
      q = w[$bits(q)-1:0];
      g = v[$bits(g)-1:0];
      if (w[63]) q.lea_reg = q.postbyte[7:6];
      if (q.lea_reg == 2'h3) q.lea_reg = 2'h2;
      if (w[62]) {q.prefix, q.opcode} = 16'h1809;
      if (i == 0) begin
        q.kind = iag_pkg::IAG_OP_MOVE;
        {q.prefix, q.opcode} = 16'h1809;
        q.dst_mode = iag_pkg::IAG_AM_IMM;
        q.src_mode = iag_pkg::IAG_AM_EXT;
        q.postbyte = 8'hC4;
        g.pc_raw = 16'h1005;
      end
      if (i == 1) begin
        q.kind = iag_pkg::IAG_OP_LEA;
        q.postbyte = 8'hA7;
        q.lea_reg = 2'h2;
        g.sp = 16'hFFFC;
      end
      if (i == 2) begin
        q.kind = iag_pkg::IAG_OP_MOVE;
        q.dst_mode = iag_pkg::IAG_AM_IDX;
        q.src_mode = iag_pkg::IAG_AM_IDX;
        q.postbyte = 8'hDF;
      end
      issue(q, g);
    end
    repeat (20) @(posedge clock);
    chk("pending", 64'(pend.size()), 64'h0);
    conclude();
  end
endmodule
